//--- src/pmc_defines.vh
// Operation
// - standby stops system clock, ports high impedance
// - standby wake restarts oscillator, waits, then exception
// - standby exit speed chosen by medium-speed bit
// - mask flag or disabled interrupt blocks wake
// - reset pin low restarts oscillator; hold until stable
// - watch keeps timers only, pins hold state
// - watch wake target from low/medium bits, wait
// - subsleep halts CPU; interrupt returns to subactive
// - subactive runs CPU from subclock, oscillator off
// - subactive sleep picks subsleep, active or watch
// - subactive divider 2/4/8 applied at sleep
// - medium speed peripherals clocked by select field
// - medium speed sleep picks standby, watch or sleep
// - direct-transition bit switches modes, then exception
// - disabled direct interrupt falls back to sleep/watch
// - masked direct attempt enters unwakeable sleep/watch
// - high to medium direct, passing through sleep
// - medium to high direct, passing through sleep
// - active to subactive direct, passing through watch
// - subactive to active direct through watch, wait
// - direct transition spends two plus one states
// - medium entry may start half state early
// - sleep halts CPU; wake to same speed
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// mode encodings
`define PMC_ST_ACT_HI   4'h0
`define PMC_ST_ACT_MED  4'h1
`define PMC_ST_SLP_HI   4'h2
`define PMC_ST_SLP_MED  4'h3
`define PMC_ST_STBY     4'h4
`define PMC_ST_WATCH    4'h5
`define PMC_ST_SUBACT   4'h6
`define PMC_ST_SUBSLP   4'h7
`define PMC_ST_SETTLE   4'h8
`define PMC_ST_DT_SLP   4'h9
`define PMC_ST_DT_WATCH 4'ha
`define PMC_ST_RST_HOLD 4'hb

// register word indices (byte address = 4 * index)
`define PMC_ADR_SYS1    2'h0
`define PMC_ADR_SYS2    2'h1
`define PMC_ADR_TMR     2'h2
`define PMC_ADR_STAT    2'h3

// system_control_one fields
`define PMC_SOFTWARE_STANDBY_BIT_BIT    7
`define PMC_STS_MSB     6
`define PMC_STS_LSB     4
`define PMC_LOW_SPEED_ON_BIT_BIT    3
`define PMC_MA_MSB      1
`define PMC_MA_LSB      0
// system_control_two fields
`define PMC_DIRECT_TRANSITION_ON_BIT_BIT    4
`define PMC_MEDIUM_SPEED_ON_BIT_BIT    3
`define PMC_SA_MSB      1
`define PMC_SA_LSB      0
// timer_a_mode_register field
`define PMC_TIMER_CLOCK_SELECT_BIT_BIT    3
// status fields
`define PMC_STAT_SETTLE 4

// reset values
`define PMC_SYS1_RST    8'h00
`define PMC_SYS2_RST    8'h00
`define PMC_TMR_RST     8'h00

// state counts of a direct transition
`define PMC_SLEEP_EXEC_STATES 2
`define PMC_INTERNAL_STATES   1
`define PMC_EXC_STATES        14

`endif

//--- src/pmc_settle_cnt.v
`default_nettype none
////////////////////////////////////////////////////////////
// down counter for oscillator settling and transition states
module pmc_settle_cnt #(
  parameter W = 12
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // control
  input  wire         load_i,
  input  wire [W-1:0] load_val_i,
  // status
  output wire         busy_o,
  output wire         done_o
);

  reg [W-1:0] cnt_q;
  reg [W-1:0] cnt_d;
  localparam [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
  localparam [W-1:0] ZERO = {W{1'b0}};

  // load wins over the running count
  always @* begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = load_val_i;
    end else if (cnt_q != ZERO) begin
      cnt_d = cnt_q - ONE;
    end
  end

  // count register
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_o = (cnt_q != ZERO);
  assign done_o = (cnt_q == ONE) && !load_i;

endmodule // pmc_settle_cnt
`default_nettype wire

//--- src/pmc_mode_ctrl.v
// Added by the designer: the Wishbone slave port and the address map.
`include "pmc_defines.vh"
`default_nettype none
////////////////////////////////////////////////////////////
// power mode sequencer with classic wishbone registers
module pmc_mode_ctrl #(
  parameter CW          = 12,
  parameter SETTLE_BASE = 8
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:2]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // cpu core and interrupt controller
  input  wire        sleep_exec_i,
  input  wire        irq_req_i,
  input  wire        irq_en_i,
  input  wire        irq_mask_i,
  input  wire        dt_irq_en_i,
  input  wire        reset_pin_n_i,
  input  wire        watch_tick_i,
  // mode and clock control
  output reg  [3:0]  mode_o,
  output reg         sys_osc_en_o,
  output reg         cpu_run_o,
  output reg         periph_run_o,
  output reg         adc_pwm_run_o,
  output reg         timers_run_o,
  output reg         io_hiz_o,
  output reg         cpu_tick_o,
  output reg         periph_tick_o,
  output reg         settling_o,
  // exception starts
  output reg         exc_start_o,
  output reg         dt_exc_start_o,
  output reg         reset_exc_o
);

  ////////////////////////////////////////////////////////////
  // register file
  reg  [7:0] sys1_q;
  reg  [7:0] sys2_q;
  reg  [7:0] tmr_q;
  reg  [1:0] sa_q;
  wire       wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

  wire       software_standby_bit = sys1_q[`PMC_SOFTWARE_STANDBY_BIT_BIT];
  wire       low_speed_on_bit = sys1_q[`PMC_LOW_SPEED_ON_BIT_BIT];
  wire [2:0] sts  = sys1_q[`PMC_STS_MSB:`PMC_STS_LSB];
  wire [1:0] ma   = sys1_q[`PMC_MA_MSB:`PMC_MA_LSB];
  wire       medium_speed_on_bit = sys2_q[`PMC_MEDIUM_SPEED_ON_BIT_BIT];
  wire       direct_transition_on_bit = sys2_q[`PMC_DIRECT_TRANSITION_ON_BIT_BIT];
  wire [1:0] sa   = sys2_q[`PMC_SA_MSB:`PMC_SA_LSB];
  wire       timer_clock_select_bit = tmr_q[`PMC_TIMER_CLOCK_SELECT_BIT_BIT];

  reg  [3:0] state_q;
  reg  [3:0] state_d;
  wire       cnt_busy;
  wire       cnt_done;

  // writes land on the acknowledged cycle, lane 0 only
  always @(posedge clk_i) begin
    if (rst_i) begin
      sys1_q <= `PMC_SYS1_RST;
      sys2_q <= `PMC_SYS2_RST;
      tmr_q  <= `PMC_TMR_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `PMC_ADR_SYS1: sys1_q <= wb_dat_i[7:0];
        `PMC_ADR_SYS2: sys2_q <= wb_dat_i[7:0];
        `PMC_ADR_TMR:  tmr_q  <= wb_dat_i[7:0];
        default:       sys1_q <= sys1_q; // status is read only
      endcase
    end
  end

  // one-cycle ack with registered read data
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `PMC_ADR_SYS1: wb_dat_o <= {24'h00_0000, sys1_q};
          `PMC_ADR_SYS2: wb_dat_o <= {24'h00_0000, sys2_q};
          `PMC_ADR_TMR:  wb_dat_o <= {24'h00_0000, tmr_q};
          default:       wb_dat_o <= {27'h000_0000, cnt_busy, state_q};
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // sleep instruction decode
  function [3:0] pmc_sleep_next;
    input [3:0] cur;
    input       f_software_standby_bit;
    input       f_low_speed_on_bit;
    input       f_direct_transition_on_bit;
    input       f_timer_clock_select_bit;
    input       f_dt_ok;
    reg         sub;
    begin
      sub = (cur == `PMC_ST_SUBACT);
      if (!f_software_standby_bit) begin
        pmc_sleep_next = sub                      ? `PMC_ST_SUBSLP :
                         (f_direct_transition_on_bit && f_dt_ok)      ? `PMC_ST_DT_SLP :
                         (cur == `PMC_ST_ACT_MED) ? `PMC_ST_SLP_MED :
                                                    `PMC_ST_SLP_HI;
      end else if (f_timer_clock_select_bit) begin
        pmc_sleep_next = (f_direct_transition_on_bit && f_dt_ok && (sub || f_low_speed_on_bit)) ? `PMC_ST_DT_WATCH :
                                                                  `PMC_ST_WATCH;
      end else begin
        pmc_sleep_next = sub ? `PMC_ST_WATCH : `PMC_ST_STBY;
      end
    end
  endfunction

  // active target picked by the medium-speed bit
  function [3:0] pmc_act_tgt;
    input f_medium_speed_on_bit;
    begin
      pmc_act_tgt = f_medium_speed_on_bit ? `PMC_ST_ACT_MED : `PMC_ST_ACT_HI;
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // mode sequencer
  reg  [3:0]    tgt_q;
  reg  [3:0]    tgt_d;
  reg           dt_q;
  reg           dt_d;
  reg           ld;
  reg  [CW-1:0] ld_val;
  reg           exc_d;
  reg           dt_exc_d;
  reg           rexc_d;
  wire          wake    = irq_req_i && irq_en_i && !irq_mask_i;
  wire          dt_ok   = dt_irq_en_i && !irq_mask_i;
  wire [CW-1:0] settle  = SETTLE_BASE[CW-1:0] << sts;
  localparam integer DT_STATES = `PMC_SLEEP_EXEC_STATES + `PMC_INTERNAL_STATES;
  wire [CW-1:0] dt_cnt  = DT_STATES[CW-1:0];
  wire          sub_src = (state_q == `PMC_ST_SUBACT);

  always @* begin
    state_d  = state_q;
    tgt_d    = tgt_q;
    dt_d     = dt_q;
    ld       = 1'b0;
    ld_val   = settle;
    exc_d    = 1'b0;
    dt_exc_d = 1'b0;
    rexc_d   = 1'b0;
    if (!reset_pin_n_i) begin
      state_d = `PMC_ST_RST_HOLD;
    end else begin
      case (state_q)
        `PMC_ST_ACT_HI, `PMC_ST_ACT_MED, `PMC_ST_SUBACT: begin
          if (sleep_exec_i) begin
            state_d = pmc_sleep_next(state_q, software_standby_bit, low_speed_on_bit, direct_transition_on_bit, timer_clock_select_bit, dt_ok);
            if (state_d == `PMC_ST_DT_SLP) begin
              tgt_d  = pmc_act_tgt(medium_speed_on_bit);
              ld     = 1'b1;
              ld_val = dt_cnt;
            end
            if (state_d == `PMC_ST_DT_WATCH) begin
              tgt_d  = sub_src ? pmc_act_tgt(medium_speed_on_bit) : `PMC_ST_SUBACT;
              ld     = 1'b1;
              ld_val = sub_src ? settle : dt_cnt;
            end
          end
        end
        `PMC_ST_SLP_HI, `PMC_ST_SLP_MED, `PMC_ST_SUBSLP: begin
          if (wake) begin
            state_d = (state_q == `PMC_ST_SUBSLP)  ? `PMC_ST_SUBACT :
                      (state_q == `PMC_ST_SLP_MED) ? `PMC_ST_ACT_MED :
                                                     `PMC_ST_ACT_HI;
            exc_d   = 1'b1;
          end
        end
        `PMC_ST_STBY: begin
          if (wake) begin
            state_d = `PMC_ST_SETTLE;
            tgt_d   = pmc_act_tgt(medium_speed_on_bit);
            dt_d    = 1'b0;
            ld      = 1'b1;
          end
        end
        `PMC_ST_WATCH: begin
          if (wake) begin
            if (low_speed_on_bit) begin
              state_d = `PMC_ST_SUBACT;
              exc_d   = 1'b1;
            end else begin
              state_d = `PMC_ST_SETTLE;
              tgt_d   = pmc_act_tgt(medium_speed_on_bit);
              dt_d    = 1'b0;
              ld      = 1'b1;
            end
          end
        end
        `PMC_ST_SETTLE: begin
          if (cnt_done) begin
            state_d = tgt_q;
            exc_d   = !dt_q;
            dt_exc_d = dt_q;
          end
        end
        `PMC_ST_DT_SLP, `PMC_ST_DT_WATCH: begin
          if (cnt_done) begin
            state_d  = tgt_q;
            dt_exc_d = 1'b1;
          end
        end
        `PMC_ST_RST_HOLD: begin
          state_d = `PMC_ST_ACT_HI;
          rexc_d  = 1'b1;
        end
        default: begin
          state_d = `PMC_ST_ACT_HI;
        end
      endcase
    end
  end

  // mode, target and subactive divider latch
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= `PMC_ST_ACT_HI;
      tgt_q   <= `PMC_ST_ACT_HI;
      dt_q    <= 1'b0;
      sa_q    <= 2'h0;
    end else begin
      state_q <= state_d;
      tgt_q   <= tgt_d;
      dt_q    <= dt_d;
      if (sleep_exec_i) begin
        sa_q <= sa;
      end
    end
  end

  // settling and transition state counter
  pmc_settle_cnt #(
    .W          (CW)
  ) u_cnt (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (ld),
    .load_val_i (ld_val),
    .busy_o     (cnt_busy),
    .done_o     (cnt_done)
  );

  ////////////////////////////////////////////////////////////
  // clock enable dividers
  reg  [3:0] med_cnt_q;
  reg  [2:0] sub_cnt_q;
  wire [3:0] med_lim = (4'h2 << ma) - 4'h1;
  wire [2:0] sub_lim = sa_q[1] ? 3'h7 : ((3'h2 << sa_q[0]) - 3'h1);
  wire       med_tick = (med_cnt_q >= med_lim);
  wire       sub_tick = watch_tick_i && (sub_cnt_q >= sub_lim);

  // medium speed on system clock, subactive on watch clock ticks
  always @(posedge clk_i) begin
    if (rst_i) begin
      med_cnt_q <= 4'h0;
      sub_cnt_q <= 3'h0;
    end else begin
      med_cnt_q <= med_tick ? 4'h0 : med_cnt_q + 4'h1;
      if (watch_tick_i) begin
        sub_cnt_q <= sub_tick ? 3'h0 : sub_cnt_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // registered mode outputs
  reg  osc_d, cpu_d, per_d, adc_d, ctk_d, ptk_d;
  wire act_tgt = (tgt_d == `PMC_ST_ACT_HI) || (tgt_d == `PMC_ST_ACT_MED);

  always @* begin
    osc_d = 1'b1;
    cpu_d = 1'b0;
    per_d = 1'b1;
    adc_d = 1'b0;
    ctk_d = 1'b0;
    ptk_d = 1'b0;
    case (state_d)
      `PMC_ST_ACT_HI, `PMC_ST_ACT_MED: begin
        cpu_d = 1'b1;
        adc_d = 1'b1;
      end
      `PMC_ST_SLP_HI, `PMC_ST_SLP_MED, `PMC_ST_DT_SLP: begin
        adc_d = 1'b1;
      end
      `PMC_ST_STBY, `PMC_ST_WATCH: begin
        osc_d = 1'b0;
        per_d = 1'b0;
      end
      `PMC_ST_SUBACT: begin
        osc_d = 1'b0;
        cpu_d = 1'b1;
      end
      `PMC_ST_SUBSLP: begin
        osc_d = 1'b0;
      end
      `PMC_ST_DT_WATCH: begin
        osc_d = act_tgt;
        per_d = 1'b0;
      end
      default: begin
        per_d = 1'b0; // settling and reset hold
      end
    endcase
    case (state_q)
      `PMC_ST_ACT_HI:  {ctk_d, ptk_d} = 2'h3;
      `PMC_ST_SLP_HI:  ptk_d = 1'b1;
      `PMC_ST_ACT_MED: {ctk_d, ptk_d} = {2{med_tick}};
      `PMC_ST_SLP_MED: ptk_d = med_tick;
      `PMC_ST_SUBACT:  {ctk_d, ptk_d} = {2{sub_tick}};
      `PMC_ST_SUBSLP: ptk_d = sub_tick;
      default: ptk_d = 1'b0;
    endcase
  end

  // output flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_o         <= `PMC_ST_ACT_HI;
      {sys_osc_en_o, cpu_run_o, periph_run_o, adc_pwm_run_o, timers_run_o} <= 5'h1f;
      {io_hiz_o, cpu_tick_o, periph_tick_o, settling_o} <= 4'h0;
      {exc_start_o, dt_exc_start_o, reset_exc_o} <= 3'h0;
    end else begin
      mode_o         <= state_d;
      sys_osc_en_o   <= osc_d;
      cpu_run_o      <= cpu_d;
      periph_run_o   <= per_d;
      adc_pwm_run_o  <= adc_d;
      timers_run_o   <= (state_d != `PMC_ST_STBY);
      io_hiz_o       <= (state_d == `PMC_ST_STBY);
      cpu_tick_o     <= ctk_d;
      periph_tick_o  <= ptk_d;
      settling_o     <= (state_d == `PMC_ST_SETTLE);
      exc_start_o    <= exc_d;
      dt_exc_start_o <= dt_exc_d;
      reset_exc_o    <= rexc_d;
    end
  end

endmodule // pmc_mode_ctrl
`default_nettype wire

//--- bench/pmc_cpu_model.sv
`default_nettype none
//////////////////////////////////////////
// cpu core, interrupt controller and watch clock stand-in
module pmc_cpu_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // bench commands
  input  wire logic irq_go_i,
  input  wire logic pin_go_i,
  // from the sequencer
  input  wire logic exc_start_i,
  input  wire logic reset_exc_i,
  input  wire logic sys_osc_en_i,
  // towards the sequencer
  output logic      irq_req_o,
  output logic      reset_pin_n_o,
  output logic      watch_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wdiv_q;
  logic [3:0] hold_q;
  // watch tick every fourth cycle; request pending until its exception starts
  always @(posedge clk_i) begin
    wdiv_q <= rst_i ? 2'h0 : wdiv_q + 2'h1;
    watch_tick_o <= !rst_i && wdiv_q == 2'h3;
    if (rst_i || exc_start_i || reset_exc_i)
      irq_req_o <= 1'b0;
    else if (irq_go_i)
      irq_req_o <= 1'b1;
    // pin kept low until the oscillator has run for a while
    if (rst_i)
      reset_pin_n_o <= 1'b1;
    else if (pin_go_i)
      reset_pin_n_o <= 1'b0;
    else if (hold_q == 4'hf)
      reset_pin_n_o <= 1'b1;
    if (rst_i || reset_pin_n_o)
      hold_q <= 4'h0;
    else if (sys_osc_en_i)
      hold_q <= hold_q + 4'h1;
  end
endmodule // pmc_cpu_model
`default_nettype wire

//--- bench/pmc_mode_ctrl_monitor.sv
`include "pmc_defines.vh"
`default_nettype none
//////////////////////////////////////////
// mode and clock-gate checker at the sequencer ports
module pmc_mode_ctrl_monitor (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // cpu side
  input wire logic       irq_req_i,
  input wire logic       irq_en_i,
  input wire logic       irq_mask_i,
  input wire logic       reset_pin_n_i,
  // mode and gates
  input wire logic [3:0] mode_o,
  input wire logic       sys_osc_en_o,
  input wire logic       cpu_run_o,
  input wire logic       periph_run_o,
  input wire logic       adc_pwm_run_o,
  input wire logic       timers_run_o,
  input wire logic       io_hiz_o,
  input wire logic       settling_o,
  // exception pulses
  input wire logic       exc_start_o,
  input wire logic       dt_exc_start_o,
  input wire logic       reset_exc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // qualified wake and halted-mode decode
  wire wake_w = irq_req_i && irq_en_i && !irq_mask_i && reset_pin_n_i;
  wire nap_w = mode_o inside {`PMC_ST_SLP_HI, `PMC_ST_SLP_MED, `PMC_ST_STBY, `PMC_ST_WATCH, `PMC_ST_SUBSLP};
  stby_pins_a: assert property (
    mode_o == `PMC_ST_STBY |-> io_hiz_o && !sys_osc_en_o && !cpu_run_o && !periph_run_o)
    else $error("standby gates wrong");
  no_wake_a: assert property (
    nap_w && !wake_w && reset_pin_n_i |=> $stable(mode_o)) else $error("woke without interrupt");
  stby_wake_a: assert property (
    mode_o == `PMC_ST_STBY && wake_w |=> mode_o == `PMC_ST_SETTLE && sys_osc_en_o)
    else $error("standby wake wrong");
  settle_osc_a: assert property (
    mode_o == `PMC_ST_SETTLE |-> sys_osc_en_o && settling_o && !cpu_run_o) else $error("settle gates wrong");
  watch_keep_a: assert property (
    mode_o == `PMC_ST_WATCH |-> timers_run_o && !sys_osc_en_o && !cpu_run_o && !periph_run_o && !io_hiz_o)
    else $error("watch gates wrong");
  sub_run_a: assert property (
    mode_o == `PMC_ST_SUBACT |-> cpu_run_o && periph_run_o && !adc_pwm_run_o && !sys_osc_en_o)
    else $error("subactive gates wrong");
  subslp_wake_a: assert property (
    mode_o == `PMC_ST_SUBSLP && wake_w |=> mode_o == `PMC_ST_SUBACT && exc_start_o)
    else $error("subsleep wake wrong");
  nap_wake_a: assert property (
    mode_o inside {`PMC_ST_SLP_HI, `PMC_ST_SLP_MED} && wake_w |=> mode_o == $past(mode_o) - 4'h2 && exc_start_o)
    else $error("sleep wake wrong");
  dt_len_a: assert property (
    $rose(mode_o == `PMC_ST_DT_SLP) |-> ##[3:4] dt_exc_start_o) else $error("direct transition length wrong");
  pin_hold_a: assert property (
    !reset_pin_n_i |=> mode_o == `PMC_ST_RST_HOLD && sys_osc_en_o && !cpu_run_o) else $error("pin hold wrong");
  pin_exc_a: assert property (
    mode_o == `PMC_ST_RST_HOLD && reset_pin_n_i |=> mode_o == `PMC_ST_ACT_HI && reset_exc_o)
    else $error("reset exception wrong");
  // main scenarios reached
  stby_c: cover property (mode_o == `PMC_ST_STBY && wake_w);
  dt_c: cover property ($rose(mode_o == `PMC_ST_DT_SLP));
  sub_c: cover property ($rose(mode_o == `PMC_ST_SUBACT));
endmodule // pmc_mode_ctrl_monitor
bind pmc_mode_ctrl pmc_mode_ctrl_monitor mon (.*);
`default_nettype wire

//--- bench/tb_pmc_mode_ctrl.sv
`include "pmc_defines.vh"
`default_nettype none
//////////////////////////////////////////
// self-checking bench for the power mode sequencer
module tb_pmc_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_go, pin_go;
  logic [3:2]  wb_adr_i;
  logic [3:0]  wb_sel_i, mode_o, m;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        sleep_exec_i, irq_req_i, irq_en_i, irq_mask_i, dt_irq_en_i, reset_pin_n_i, watch_tick_i;
  logic        sys_osc_en_o, cpu_run_o, periph_run_o, adc_pwm_run_o, timers_run_o, io_hiz_o, cpu_tick_o;
  logic        periph_tick_o, settling_o, exc_start_o, dt_exc_start_o, reset_exc_o;
  logic [7:0]  s1, s2, tm, rd, w, ma, sa;
  int          n_fail, compares, n;
  pmc_mode_ctrl #(.SETTLE_BASE(1)) dut (.*);
  pmc_cpu_model partner (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .irq_go_i      (irq_go),
    .pin_go_i      (pin_go),
    .exc_start_i   (exc_start_o),
    .reset_exc_i   (reset_exc_o),
    .sys_osc_en_i  (sys_osc_en_o),
    .irq_req_o     (irq_req_i),
    .reset_pin_n_o (reset_pin_n_i),
    .watch_tick_o  (watch_tick_i)
  );
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, read data kept in rd
  task automatic wb(input logic we, input logic [1:0] a, input logic [7:0] d, input logic [3:0] sel);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h00_0000, d};
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
    chk(wb_ack_o, 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // wait for a mode, cycles taken kept in n
  task automatic wmode(input logic [3:0] e);
    n = 0;
    do begin @(posedge clk_i); n++; end while (mode_o !== e && n < 300);
    chk(mode_o, e);
  endtask
  // reference: mode chosen by a sleep instruction
  function automatic logic [3:0] nx(input logic [3:0] c);
    logic dt;
    dt = s2[4] && dt_irq_en_i && !irq_mask_i;
    if (!s1[7]) return c == `PMC_ST_SUBACT ? `PMC_ST_SUBSLP : dt ? `PMC_ST_DT_SLP : c + 4'h2;
    if (tm[3]) return dt && (c == `PMC_ST_SUBACT || s1[3]) ? `PMC_ST_DT_WATCH : `PMC_ST_WATCH;
    return c == `PMC_ST_SUBACT ? `PMC_ST_WATCH : `PMC_ST_STBY;
  endfunction
  // configure, sleep; unless direct, refuse a blocked wake and stop there if masked, then wake; follow to the end mode
  task automatic seq(input logic [7:0] a, b, c);
    logic [3:0] e, f, ms;
    logic       sl, dt;
    s1 = a;
    s2 = b;
    tm = c;
    wb(1'b1, 2'h0, a, 4'h1);
    wb(1'b1, 2'h1, b, 4'h1);
    wb(1'b1, 2'h2, c, 4'h1);
    sleep_exec_i <= 1'b1;
    @(posedge clk_i);
    sleep_exec_i <= 1'b0;
    e = nx(m);
    wmode(e);
    ms = s2[3] ? `PMC_ST_ACT_MED : `PMC_ST_ACT_HI;
    dt = e inside {`PMC_ST_DT_SLP, `PMC_ST_DT_WATCH};
    sl = e == `PMC_ST_STBY || (e == `PMC_ST_WATCH && !s1[3]) || (e == `PMC_ST_DT_WATCH && m == `PMC_ST_SUBACT);
    case (e)
      `PMC_ST_SLP_HI: f = `PMC_ST_ACT_HI;
      `PMC_ST_SLP_MED: f = `PMC_ST_ACT_MED;
      `PMC_ST_SUBSLP: f = `PMC_ST_SUBACT;
      `PMC_ST_DT_WATCH: f = m == `PMC_ST_SUBACT ? ms : `PMC_ST_SUBACT;
      `PMC_ST_WATCH: f = s1[3] ? `PMC_ST_SUBACT : ms;
      default: f = ms;
    endcase
    if (!dt) begin
      irq_en_i <= irq_mask_i;
      irq_go <= 1'b1;
      @(posedge clk_i);
      irq_go <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk(mode_o, e);
      if (irq_mask_i) return;
      irq_en_i <= 1'b1;
      if (sl) wmode(`PMC_ST_SETTLE);
    end
    wmode(f);
    chk(dt ? dt_exc_start_o : exc_start_o, 1'b1);
    chk(n >= (sl ? 1 << s1[6:4] : dt ? 3 : 1) && n <= (sl ? 1 << s1[6:4] : dt ? 3 : 1) + 4, 1);
    m = f;
  endtask
  // cycles between two peripheral ticks
  task automatic gap(input int e);
    int k;
    k = 0;
    do @(posedge clk_i); while (periph_tick_o !== 1'b1);
    do begin @(posedge clk_i); k++; end while (periph_tick_o !== 1'b1 && k < 99);
    chk(k, e);
    chk(cpu_tick_o, 1'b1);
  endtask
  // verdict
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    finish_test;
  end
  // main sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, sleep_exec_i, irq_go, pin_go, irq_mask_i} = 7'h00;
    {irq_en_i, dt_irq_en_i, rst_i} = 3'h7;
    wb_adr_i = 2'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    n_fail = 0;
    compares = 0;
    m = `PMC_ST_ACT_HI;
    void'($urandom(63118));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, i[1:0], 8'h00, 4'hf);
      chk(rd, 8'h00);
    end
    wb(1'b1, 2'h0, 8'hff, 4'he);
    wb(1'b1, 2'h3, 8'hff, 4'h1);
    for (int i = 0; i < 4; i += 3) begin
      wb(1'b0, i[1:0], 8'h00, 4'hf);
      chk(rd, 8'h00);
    end
    repeat (4) begin
      w = $urandom;
      wb(1'b1, 2'h0, w, 4'h1);
      wb(1'b0, 2'h0, 8'h00, 4'hf);
      chk(rd & 8'hfb, w & 8'hfb);
    end
    w = $urandom_range(7, 0) << 4;
    ma = $urandom_range(3, 0);
    sa = $urandom_range(3, 0);
    seq(8'h80 | w | ma, 8'h08, 8'h00);
    gap(2 << ma);
    seq(ma, 8'h00, 8'h00);
    seq(8'h00, 8'h10, 8'h00);
    seq(8'h00, 8'h18, 8'h00);
    dt_irq_en_i <= 1'b0;
    seq(8'h00, 8'h10, 8'h00);
    dt_irq_en_i <= 1'b1;
    seq(8'h88, 8'h10 | sa, 8'h08);
    wb(1'b1, 2'h1, 8'h10 | ~sa & 8'h03, 4'h1);
    gap(sa[1] ? 32 : sa[0] ? 16 : 8);
    seq(8'h00, 8'h00, 8'h00);
    seq(8'h88, 8'h00, 8'h08);
    seq(8'h80 | w, 8'h10, 8'h08);
    seq(8'h80 | w, 8'h08, 8'h08);
    irq_mask_i <= 1'b1;
    seq(8'h00, 8'h18, 8'h00);
    pin_go <= 1'b1;
    @(posedge clk_i);
    pin_go <= 1'b0;
    wmode(`PMC_ST_RST_HOLD);
    wmode(`PMC_ST_ACT_HI);
    chk(reset_exc_o, 1'b1);
    finish_test;
  end
endmodule // tb_pmc_mode_ctrl
`default_nettype wire
